//--- inc/scrs_pkg.sv
// shared types of the sensor config register slice
package scrs_pkg;

   // avalon request as seen by the slave
   typedef struct packed {
      logic        read;
      logic        write;
      logic [9:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } scrs_avs_req_t;

   // one register write handed from the bus slave to the bank
   typedef struct packed {
      logic        stb;
      logic [7:0]  index;
      logic [15:0] data;
      logic [1:0]  be;
   } scrs_reg_wr_t;

endpackage : scrs_pkg

//--- inc/scrs_regs.svh
// register indices, reset values and field positions of the config slice
`ifndef SCRS_REGS_SVH
`define SCRS_REGS_SVH

// register indices; byte address is four times the index
`define SCRS_IDX_REF_BIAS   8'h46
`define SCRS_IDX_PUMP       8'h48
`define SCRS_IDX_SPARE0     8'h50
`define SCRS_IDX_SPARE1     8'h51
`define SCRS_IDX_TEMP_CTL   8'h60
`define SCRS_IDX_TEMP_RES   8'h61
`define SCRS_IDX_LANE_PWR   8'h70
`define SCRS_IDX_DARK_CAL   8'h80
`define SCRS_IDX_AUTO_CAL   8'h81
`define SCRS_IDX_CAL_ERR    8'h88

// reset values
`define SCRS_RST_REF_BIAS   16'h8888
`define SCRS_RST_PUMP       16'h1200
`define SCRS_RST_SPARE0     16'h0000
`define SCRS_RST_SPARE1     16'h8881
`define SCRS_RST_TEMP_CTL   16'h0000
`define SCRS_RST_TEMP_RES   8'h00
`define SCRS_RST_LANE_PWR   16'h0000
`define SCRS_RST_DARK_CAL   16'h4008
`define SCRS_RST_AUTO_CAL   16'hc001
`define SCRS_RST_CAL_ERR    8'h00
`define SCRS_RST_DATA_LANES 4'h0
`define SCRS_RST_SMP_CNT    8'h01
`define SCRS_RST_RDATA      32'h0000_0000
`define SCRS_ZERO16         16'h0000
`define SCRS_ZERO8          8'h00
`define SCRS_ONE8           8'h01

// field positions
`define SCRS_PUMP_PDT_EN    0
`define SCRS_PUMP_FD_EN     1
`define SCRS_PUMP_PDT_LSB   8
`define SCRS_PUMP_PDT_MSB   10
`define SCRS_PUMP_FD_LSB    12
`define SCRS_PUMP_FD_MSB    14
`define SCRS_TEMP_EN        0
`define SCRS_LANE_CLK       0
`define SCRS_LANE_SYNC      1
`define SCRS_LANE_DATA      2
`define SCRS_DARK_TGT_LSB   0
`define SCRS_DARK_TGT_MSB   7
`define SCRS_DARK_SMP_LSB   8
`define SCRS_DARK_SMP_MSB   10
`define SCRS_AUTO_EN        0
`define SCRS_AUTO_OFS_LSB   1
`define SCRS_AUTO_OFS_MSB   9
`define SCRS_AUTO_SUB       10
`define SCRS_ADDR_IDX_LSB   2
`define SCRS_ADDR_IDX_MSB   9
`define SCRS_DATA_LANES     4

`endif

//--- tb/scrs_top_properties.sv
// port assertions for the sensor config register slice
`timescale 1ns/100ps
`default_nettype none
module scrs_top_properties (
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic [9:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic        o_avs_waitrequest,
   input wire logic        o_pd_trans_pump_en,
   input wire logic        o_fd_pump_en,
   input wire logic [2:0]  o_pd_trans_trim,
   input wire logic [2:0]  o_fd_trim,
   input wire logic        o_temp_diode_en,
   input wire logic        o_clk_lane_up,
   input wire logic        o_sync_lane_up,
   input wire logic [3:0]  o_data_lanes_up,
   input wire logic [7:0]  o_black_target,
   input wire logic [2:0]  o_black_samples_log2,
   input wire logic [7:0]  o_black_sample_count,
   input wire logic        o_auto_cal_en
);
   logic [7:0]  idx;
   logic        acc;
   logic        b0;
   logic [15:0] wd;
   // accepted write and its word index
   assign idx = i_avs_address[9:2];
   assign acc = i_avs_write && !o_avs_waitrequest;
   assign b0 = acc && i_avs_byteenable[0];
   assign wd = i_avs_writedata[15:0];
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   AST_WAIT_ONE: assert property ($fell(o_avs_waitrequest) |=>
      o_avs_waitrequest) else $error("wait state gap too long");
   AST_ANSWER: assert property ($rose(i_avs_read || i_avs_write) |=>
      !o_avs_waitrequest) else $error("no answer after one wait");
   AST_PUMP_EN: assert property (b0 && idx == 8'h48 |=>
      {o_fd_pump_en, o_pd_trans_pump_en} == $past(wd[1:0]))
      else $error("pump enables wrong");
   AST_PUMP_TRIM: assert property (acc && idx == 8'h48 &&
      i_avs_byteenable[1] |=> {o_fd_trim, o_pd_trans_trim} ==
      {$past(wd[14:12]), $past(wd[10:8])}) else $error("trims wrong");
   AST_LANES: assert property (b0 && idx == 8'h70 |=>
      {o_sync_lane_up, o_clk_lane_up} == $past(wd[1:0]))
      else $error("clock or sync lane wrong");
   AST_DATA_LANES: assert property (b0 && idx == 8'h70 |=> ##1
      o_data_lanes_up == {4{$past(wd[2], 2)}}) else $error("data lanes");
   AST_TARGET: assert property (b0 && idx == 8'h80 |=>
      o_black_target == $past(wd[7:0])) else $error("black target");
   AST_SMP_CNT: assert property (1'b1 |=> o_black_sample_count ==
      (8'h01 << $past(o_black_samples_log2))) else $error("sample count");
   AST_AUTO_CAL: assert property (b0 && idx == 8'h81 |=>
      o_auto_cal_en == $past(wd[0])) else $error("auto cal enable");
   AST_TEMP_EN: assert property (b0 && idx == 8'h60 |=>
      o_temp_diode_en == $past(wd[0])) else $error("diode enable");
   AST_RST_OUTS: assert property ($fell(i_srst) |->
      o_pd_trans_trim == 3'h2 && o_fd_trim == 3'h1 && !o_clk_lane_up &&
      o_black_target == 8'h08 && o_avs_waitrequest) else $error("reset");
   // main scenarios reached
   cover property (b0 && idx == 8'h48);
   cover property (b0 && idx == 8'h70 && wd[2]);
   cover property ($fell(i_srst));
endmodule : scrs_top_properties
bind scrs_top scrs_top_properties u_scrs_top_properties (.i_clk, .i_srst,
   .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .i_avs_byteenable, .o_avs_waitrequest, .o_pd_trans_pump_en,
   .o_fd_pump_en, .o_pd_trans_trim, .o_fd_trim, .o_temp_diode_en,
   .o_clk_lane_up, .o_sync_lane_up, .o_data_lanes_up, .o_black_target,
   .o_black_samples_log2, .o_black_sample_count, .o_auto_cal_en);
`default_nettype wire

//--- tb/scrs_top_tb_top.sv
// self-checking bench for the sensor config register slice
`timescale 1ns/100ps
`default_nettype none
module scrs_top_tb_top;
   logic        i_clk, i_srst, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [9:0]  i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata;
   logic [3:0]  i_avs_byteenable, o_data_lanes_up;
   logic        i_temp_valid, i_cal_start, o_pd_trans_pump_en, o_fd_pump_en;
   logic [7:0]  i_temp_code, i_cal_short, o_black_target;
   logic [7:0]  o_black_sample_count;
   logic [2:0]  o_pd_trans_trim, o_fd_trim, o_black_samples_log2;
   logic        o_temp_diode_en, o_clk_lane_up, o_sync_lane_up;
   logic        o_auto_cal_en, o_manual_offset_sub;
   logic [8:0]  o_manual_offset;
   int          n_fail, checked, cyc, i;
   logic [15:0] seed, d;
   logic [1:0]  be;
   logic [31:0] expq [$];
   logic [7:0]  ix [10];
   logic [15:0] rv [10];
   logic [15:0] sh [10];

   scrs_top u_scrs_top (.i_clk, .i_srst, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
      .o_avs_waitrequest, .i_temp_valid, .i_temp_code, .i_cal_start,
      .i_cal_short, .o_pd_trans_pump_en, .o_fd_pump_en, .o_pd_trans_trim,
      .o_fd_trim, .o_temp_diode_en, .o_clk_lane_up, .o_sync_lane_up,
      .o_data_lanes_up, .o_black_target, .o_black_samples_log2,
      .o_black_sample_count, .o_auto_cal_en, .o_manual_offset,
      .o_manual_offset_sub);

   // next pseudo-random word
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic summarize();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] x,
                      input logic [15:0] v, input logic [1:0] b);
      i_avs_address <= {x, 2'b00};
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= {16'h0000, v};
      i_avs_byteenable <= {2'b00, b};
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0) begin
         @(posedge i_clk);
      end
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clk);
   endtask : bus

   task automatic rd(input logic [7:0] x, input logic [15:0] e);
      expq.push_back({16'h0000, e});
      bus(1'b0, x, 16'h0000, 2'b00);
   endtask : rd

   // one-cycle pulse on the status inputs
   task automatic drive(input logic tv, input logic cs, input logic [7:0] s8);
      i_temp_valid <= tv;
      i_temp_code <= seed[7:0];
      i_cal_start <= cs;
      i_cal_short <= s8;
      @(posedge i_clk);
      i_temp_valid <= 1'b0;
      i_cal_start <= 1'b0;
      i_cal_short <= 8'h00;
      @(posedge i_clk);
   endtask : drive

   // control outputs against the shadow words
   task automatic outs();
      @(negedge i_clk);
      chk(o_pd_trans_pump_en, sh[1][0]);
      chk(o_fd_pump_en, sh[1][1]);
      chk({o_fd_trim, o_pd_trans_trim}, {sh[1][14:12], sh[1][10:8]});
      chk(o_temp_diode_en, sh[4][0]);
      chk(o_clk_lane_up, sh[6][0]);
      chk(o_sync_lane_up, sh[6][1]);
      chk(o_data_lanes_up, {4{sh[6][2]}});
      chk(o_black_target, sh[7][7:0]);
      chk({o_black_sample_count, o_black_samples_log2},
          {8'h01 << sh[7][10:8], sh[7][10:8]});
      chk({o_manual_offset_sub, o_manual_offset, o_auto_cal_en},
          sh[8][10:0]);
      @(posedge i_clk);
   endtask : outs

   task automatic rst();
      i_srst <= 1'b1;
      repeat (6) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      sh = rv;
      for (int k = 0; k < 10; k++) rd(ix[k], sh[k]);
      rd(8'h47, 16'h0000);
      outs();
   endtask : rst

   // each captured read against the oldest note
   always @(posedge i_clk) begin
      if (i_avs_read && o_avs_waitrequest === 1'b0) begin
         chk(o_avs_readdata, expq.pop_front());
      end
   end

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   initial begin
      i_srst = 1'b1;
      i_avs_address = 10'h000;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = 32'h0000_0000;
      i_avs_byteenable = 4'h0;
      i_temp_valid = 1'b0;
      i_temp_code = 8'h00;
      i_cal_start = 1'b0;
      i_cal_short = 8'h00;
      seed = 16'h0063;
      ix = '{8'h46, 8'h48, 8'h50, 8'h51, 8'h60, 8'h61, 8'h70, 8'h80,
             8'h81, 8'h88};
      rv = '{16'h8888, 16'h1200, 16'h0000, 16'h8881, 16'h0000, 16'h0000,
             16'h0000, 16'h4008, 16'hc001, 16'h0000};
      rst();
      // random store and readback; read-only words keep their value
      for (int k = 0; k < 30; k++) begin
         i = k % 10;
         seed = lfsr(seed);
         d = seed;
         seed = lfsr(seed);
         be = seed[1:0];
         bus(1'b1, ix[i], d, be);
         if (i != 5 && i != 9) begin
            sh[i] = {be[1] ? d[15:8] : sh[i][15:8],
                     be[0] ? d[7:0] : sh[i][7:0]};
         end
         rd(ix[i], sh[i]);
         outs();
      end
      bus(1'b1, 8'h47, 16'hffff, 2'b11);
      rd(8'h47, 16'h0000);
      // every sample count code
      for (int k = 0; k < 8; k++) begin
         sh[7] = {5'h08, k[2:0], 8'h08};
         bus(1'b1, 8'h80, sh[7], 2'b11);
         outs();
      end
      // thermal code ignored while the diode is off
      sh[4] = 16'h0000;
      bus(1'b1, 8'h60, 16'h0000, 2'b11);
      drive(1'b1, 1'b0, 8'h00);
      rd(8'h61, 16'h0000);
      sh[4] = 16'h0001;
      bus(1'b1, 8'h60, 16'h0001, 2'b11);
      drive(1'b1, 1'b0, 8'h00);
      rd(8'h61, {8'h00, seed[7:0]});
      // error flags: set, set beats clear, clear
      drive(1'b0, 1'b0, 8'h28);
      rd(8'h88, 16'h0028);
      drive(1'b0, 1'b1, 8'h81);
      rd(8'h88, 16'h0081);
      drive(1'b0, 1'b1, 8'h00);
      rd(8'h88, 16'h0000);
      // all lanes up, then reset in mid-run
      sh[6] = 16'h0007;
      bus(1'b1, 8'h70, 16'h0007, 2'b11);
      outs();
      rst();
      summarize();
   end
endmodule : scrs_top_tb_top
`default_nettype wire

//--- verilog/scrs_avs_slave.sv
// avalon-mm slave front end with one wait state
`timescale 1ns/100ps
`default_nettype none
`include "scrs_regs.svh"

module scrs_avs_slave (
   input  wire logic                   i_clk,
   input  wire logic                   i_srst,
   input  wire scrs_pkg::scrs_avs_req_t i_req,
   input  wire logic [31:0]            i_rdata,
   output logic [31:0]                 o_readdata,
   output logic                        o_waitrequest,
   output logic [7:0]                  o_rd_index,
   output scrs_pkg::scrs_reg_wr_t      o_wr
);

   logic        wait_reg;
   logic [31:0] rdata_reg;

   // waitrequest drops for one cycle after a request is seen
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wait_reg <= 1'b1;
      end else if (!wait_reg) begin
         wait_reg <= 1'b1;
      end else if (i_req.read || i_req.write) begin
         wait_reg <= 1'b0;
      end
   end

   // read data captured while waitrequest is still high
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_reg <= `SCRS_RST_RDATA;
      end else if (i_req.read && wait_reg) begin
         rdata_reg <= i_rdata;
      end
   end

   // word index from the byte address
   assign o_rd_index = i_req.address[`SCRS_ADDR_IDX_MSB:`SCRS_ADDR_IDX_LSB];

   // write commits at the edge where waitrequest is low
   assign o_wr.stb   = i_req.write && !wait_reg;
   assign o_wr.index = o_rd_index;
   assign o_wr.data  = i_req.writedata[15:0];
   assign o_wr.be    = i_req.byteenable[1:0];

   assign o_readdata    = rdata_reg;
   assign o_waitrequest = wait_reg;

endmodule : scrs_avs_slave
`default_nettype wire

//--- verilog/scrs_top.sv
// sensor configuration register slice: pumps, thermal, lanes, dark cal
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "scrs_regs.svh"

// Functional notes
// - pump control bit 0 enables transfer pump
// - pump control bit 1 enables diffusion pump
// - pump trims at 10:8 and 14:12, reset 0x1200
// - thermal diode enable bit, 8-bit read-only result
// - lane power bit 0 powers clock lane
// - lane power bit 1 powers sync lane
// - lane power bit 2 powers all data lanes
// - dark cal bits 7:0 set black target
// - dark cal bits 10:8 give log2 sample count
// - auto calibration enable, else manual offset
// - per-channel sticky calibration error flags, read-only
module scrs_top (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   // avalon-mm register port
   input  wire logic [9:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // thermal readout from the sensor adc logic
   input  wire logic        i_temp_valid,
   input  wire logic [7:0]  i_temp_code,
   // calibration datapath status
   input  wire logic        i_cal_start,
   input  wire logic [7:0]  i_cal_short,
   // charge pump controls
   output logic             o_pd_trans_pump_en,
   output logic             o_fd_pump_en,
   output logic [2:0]       o_pd_trans_trim,
   output logic [2:0]       o_fd_trim,
   // thermal diode
   output logic             o_temp_diode_en,
   // serializer lane power, one means powered up
   output logic             o_clk_lane_up,
   output logic             o_sync_lane_up,
   output logic [3:0]       o_data_lanes_up,
   // dark level calibration
   output logic [7:0]       o_black_target,
   output logic [2:0]       o_black_samples_log2,
   output logic [7:0]       o_black_sample_count,
   output logic             o_auto_cal_en,
   output logic [8:0]       o_manual_offset,
   output logic             o_manual_offset_sub
);

   // bus side signals
   scrs_pkg::scrs_avs_req_t avs_req;
   scrs_pkg::scrs_reg_wr_t  reg_wr;
   logic [7:0]              rd_index;
   logic [31:0]             rd_mux;

   // software-writable words
   logic [15:0] ref_bias_reg;
   logic [15:0] pump_reg;
   logic [15:0] spare0_reg;
   logic [15:0] spare1_reg;
   logic [15:0] temp_ctl_reg;
   logic [15:0] lane_pwr_reg;
   logic [15:0] dark_cal_reg;
   logic [15:0] auto_cal_reg;

   // hardware-owned and derived state
   logic [7:0]  temp_res_reg;
   logic [7:0]  cal_err_reg;
   logic [7:0]  cal_err_next;
   logic [7:0]  sample_count_reg;
   logic [3:0]  data_lanes_reg;

   // decoded write strobes, one per writable word
   logic        wr_ref_bias;
   logic        wr_pump;
   logic        wr_spare0;
   logic        wr_spare1;
   logic        wr_temp_ctl;
   logic        wr_lane_pwr;
   logic        wr_dark_cal;
   logic        wr_auto_cal;

   // true when the pending write targets the given index
   function automatic logic wr_hit(
      input scrs_pkg::scrs_reg_wr_t wr,
      input logic [7:0]             idx
   );
      wr_hit = wr.stb && (wr.index == idx);
   endfunction : wr_hit

   // byte-lane merge of a 16-bit register write
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [15:0] data,
      input logic [1:0]  be
   );
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = data[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = data[15:8];
      end
   endfunction : merge16

   // two raised to a 3-bit exponent
   function automatic logic [7:0] pow2(
      input logic [2:0] exp
   );
      pow2 = `SCRS_ONE8 << exp;
   endfunction : pow2

   // zero-extend a 16-bit word onto the read bus
   function automatic logic [31:0] word32(
      input logic [15:0] w
   );
      word32 = {`SCRS_ZERO16, w};
   endfunction : word32

   // zero-extend an 8-bit field onto the read bus
   function automatic logic [31:0] byte32(
      input logic [7:0] b
   );
      byte32 = {`SCRS_ZERO16, `SCRS_ZERO8, b};
   endfunction : byte32

   // gather the bus request into its carrier
   assign avs_req.read       = i_avs_read;
   assign avs_req.write      = i_avs_write;
   assign avs_req.address    = i_avs_address;
   assign avs_req.writedata  = i_avs_writedata;
   assign avs_req.byteenable = i_avs_byteenable;

   // bus slave with one wait state
   scrs_avs_slave u_slave (
      .i_clk         (i_clk),
      .i_srst        (i_srst),
      .i_req         (avs_req),
      .i_rdata       (rd_mux),
      .o_readdata    (o_avs_readdata),
      .o_waitrequest (o_avs_waitrequest),
      .o_rd_index    (rd_index),
      .o_wr          (reg_wr)
   );

   // write strobes; read-only and unmapped words get none
   assign wr_ref_bias = wr_hit(reg_wr, `SCRS_IDX_REF_BIAS);
   assign wr_pump     = wr_hit(reg_wr, `SCRS_IDX_PUMP);
   assign wr_spare0   = wr_hit(reg_wr, `SCRS_IDX_SPARE0);
   assign wr_spare1   = wr_hit(reg_wr, `SCRS_IDX_SPARE1);
   assign wr_temp_ctl = wr_hit(reg_wr, `SCRS_IDX_TEMP_CTL);
   assign wr_lane_pwr = wr_hit(reg_wr, `SCRS_IDX_LANE_PWR);
   assign wr_dark_cal = wr_hit(reg_wr, `SCRS_IDX_DARK_CAL);
   assign wr_auto_cal = wr_hit(reg_wr, `SCRS_IDX_AUTO_CAL);

   // analog reference bias word, stored only
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ref_bias_reg <= `SCRS_RST_REF_BIAS;
      end else if (wr_ref_bias) begin
         ref_bias_reg <= merge16(ref_bias_reg, reg_wr.data,
                                 reg_wr.be);
      end
   end

   // charge pump enables and trims
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pump_reg <= `SCRS_RST_PUMP;
      end else if (wr_pump) begin
         pump_reg <= merge16(pump_reg, reg_wr.data, reg_wr.be);
      end
   end

   // spare block words, stored and returned
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         spare0_reg <= `SCRS_RST_SPARE0;
      end else if (wr_spare0) begin
         spare0_reg <= merge16(spare0_reg, reg_wr.data, reg_wr.be);
      end
   end

   // second spare word
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         spare1_reg <= `SCRS_RST_SPARE1;
      end else if (wr_spare1) begin
         spare1_reg <= merge16(spare1_reg, reg_wr.data, reg_wr.be);
      end
   end

   // thermal diode enable
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         temp_ctl_reg <= `SCRS_RST_TEMP_CTL;
      end else if (wr_temp_ctl) begin
         temp_ctl_reg <= merge16(temp_ctl_reg, reg_wr.data,
                                 reg_wr.be);
      end
   end

   // thermal result, taken only while the diode is on
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         temp_res_reg <= `SCRS_RST_TEMP_RES;
      end else if (i_temp_valid && temp_ctl_reg[`SCRS_TEMP_EN]) begin
         temp_res_reg <= i_temp_code;
      end
   end

   // serializer lane power
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         lane_pwr_reg <= `SCRS_RST_LANE_PWR;
      end else if (wr_lane_pwr) begin
         lane_pwr_reg <= merge16(lane_pwr_reg, reg_wr.data, reg_wr.be);
      end
   end

   // data lanes switch together from one control bit
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         data_lanes_reg <= `SCRS_RST_DATA_LANES;
      end else begin
         data_lanes_reg <=
            {`SCRS_DATA_LANES{lane_pwr_reg[`SCRS_LANE_DATA]}};
      end
   end

   // dark level target and sample exponent
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         dark_cal_reg <= `SCRS_RST_DARK_CAL;
      end else if (wr_dark_cal) begin
         dark_cal_reg <= merge16(dark_cal_reg, reg_wr.data, reg_wr.be);
      end
   end

   // sample count follows the exponent one cycle later
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sample_count_reg <= `SCRS_RST_SMP_CNT;
      end else begin
         sample_count_reg <= pow2(
            dark_cal_reg[`SCRS_DARK_SMP_MSB:`SCRS_DARK_SMP_LSB]);
      end
   end

   // auto calibration enable and manual offset
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         auto_cal_reg <= `SCRS_RST_AUTO_CAL;
      end else if (wr_auto_cal) begin
         auto_cal_reg <= merge16(auto_cal_reg, reg_wr.data, reg_wr.be);
      end
   end

   // error flags: start clears, a short channel sets; set wins
   always_comb begin
      cal_err_next = cal_err_reg;
      if (i_cal_start) begin
         cal_err_next = `SCRS_ZERO8;
      end
      // or in after the clear so a set wins
      cal_err_next = cal_err_next | i_cal_short;
   end

   // error flag register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cal_err_reg <= `SCRS_RST_CAL_ERR;
      end else begin
         cal_err_reg <= cal_err_next;
      end
   end

   // read decode, unmapped words read as zero
   always_comb begin
      rd_mux = `SCRS_RST_RDATA;
      if (rd_index == `SCRS_IDX_REF_BIAS) begin
         rd_mux = word32(ref_bias_reg);
      end else if (rd_index == `SCRS_IDX_PUMP) begin
         rd_mux = word32(pump_reg);
      end else if (rd_index == `SCRS_IDX_SPARE0) begin
         rd_mux = word32(spare0_reg);
      end else if (rd_index == `SCRS_IDX_SPARE1) begin
         rd_mux = word32(spare1_reg);
      end else if (rd_index == `SCRS_IDX_TEMP_CTL) begin
         rd_mux = word32(temp_ctl_reg);
      end else if (rd_index == `SCRS_IDX_TEMP_RES) begin
         rd_mux = byte32(temp_res_reg);
      end else if (rd_index == `SCRS_IDX_LANE_PWR) begin
         rd_mux = word32(lane_pwr_reg);
      end else if (rd_index == `SCRS_IDX_DARK_CAL) begin
         rd_mux = word32(dark_cal_reg);
      end else if (rd_index == `SCRS_IDX_AUTO_CAL) begin
         rd_mux = word32(auto_cal_reg);
      end else if (rd_index == `SCRS_IDX_CAL_ERR) begin
         rd_mux = byte32(cal_err_reg);
      end
   end

   // charge pump outputs straight from the control word
   assign o_pd_trans_pump_en = pump_reg[`SCRS_PUMP_PDT_EN];
   assign o_fd_pump_en       = pump_reg[`SCRS_PUMP_FD_EN];

   // pump trims, three bits each
   assign o_pd_trans_trim    =
      pump_reg[`SCRS_PUMP_PDT_MSB:`SCRS_PUMP_PDT_LSB];
   assign o_fd_trim          =
      pump_reg[`SCRS_PUMP_FD_MSB:`SCRS_PUMP_FD_LSB];

   // thermal diode control
   assign o_temp_diode_en = temp_ctl_reg[`SCRS_TEMP_EN];

   // lane power; zero keeps the lane powered down
   assign o_clk_lane_up   = lane_pwr_reg[`SCRS_LANE_CLK];
   assign o_sync_lane_up  = lane_pwr_reg[`SCRS_LANE_SYNC];

   // data lanes, one cycle behind their control bit
   assign o_data_lanes_up = data_lanes_reg;

   // calibration settings
   assign o_black_target       =
      dark_cal_reg[`SCRS_DARK_TGT_MSB:`SCRS_DARK_TGT_LSB];
   assign o_black_samples_log2 =
      dark_cal_reg[`SCRS_DARK_SMP_MSB:`SCRS_DARK_SMP_LSB];
   assign o_black_sample_count = sample_count_reg;

   // automatic calibration enable
   assign o_auto_cal_en        = auto_cal_reg[`SCRS_AUTO_EN];

   // manual offset and its sign, used in bypass
   assign o_manual_offset      =
      auto_cal_reg[`SCRS_AUTO_OFS_MSB:`SCRS_AUTO_OFS_LSB];
   assign o_manual_offset_sub  = auto_cal_reg[`SCRS_AUTO_SUB];

endmodule : scrs_top
`default_nettype wire
